//--- hw/spi_dv_pkg.sv
// Constants shared by the serial data path: register map, field layout, states.
// Assumes an AXI4-Lite master with byte addresses and 32-bit data.
package spi_dv_pkg;

	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_DIV = 8'h04;
	localparam logic [7:0] OFF_RX0 = 8'h10;
	localparam logic [7:0] OFF_RX1 = 8'h14;
	localparam logic [7:0] OFF_TX0 = 8'h20;
	localparam logic [7:0] OFF_TX1 = 8'h24;
	localparam logic [7:0] OFF_PAT = 8'h34;
	localparam logic [7:0] OFF_DMA = 8'h38;

	// Reset values.
	localparam logic [31:0] PAT_RESET = 32'h007fff87;
	localparam logic [31:0] ZERO_WORD = 32'h00000000;

	// Control and divisor register field positions.
	localparam int CTRL_BUSY = 0;
	localparam int LEN_LO = 8;
	localparam int LEN_W = 5;
	localparam int CNT_BIT = 16;
	localparam int POL_BIT = 17;
	localparam int DIV_B_LO = 16;

	// DMA start register field positions.
	localparam int DMA_TX_BIT = 0;
	localparam int DMA_RX_BIT = 1;

	// Bit lengths.
	localparam logic [5:0] FULL_LEN = 6'h20;
	localparam logic [5:0] VAR_LEN = 6'h10;

	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LEAD = 2'b01,
		ST_TRAIL = 2'b10,
		ST_NEXT = 2'b11
	} shift_state_t;

endpackage : spi_dv_pkg

//--- hw/spi_data_dma_clock_rate_pattern.sv
// Serial data path of an SPI master: transmit and receive words, bit length,
// variable clock pattern and DMA request logic, with an AXI4-Lite register port.
// Assumes ref_clk is the peripheral clock and miso arrives asynchronously.
//
// Operation
// [R1] Transmit words are held and sent next transfer using only the low length bits.
// [R2] Length 8 and count 0 shift out bits 7 to 0 of the first word.
// [R3] Length 0 means 32 bits; count 1 sends first word then second word.
// [R4] Each clock pattern bit picks divisor_a when zero, divisor_b when one.
// [R5] Clock pattern applies only with idle level zero and 16-bit transfers.
// [R6] Receive DMA start bit makes the block request receive moves by itself.
// [R7] Transmit DMA start bit makes the block request transmit moves by itself.
// [R8] Under DMA the block sets busy itself; software leaves busy alone.
// [R9] Received data of the last transfer lands in receive words, low bits valid.
// [R10] Busy clears once the last exchange of the count has completed.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

module rx_word_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Filling side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// Fill level.
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [$clog2(DEPTH+1)-1:0] FULL = DEPTH[$clog2(DEPTH+1)-1:0];

	generate
		if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad
			$error("rx_word_fifo depth must be a power of two of at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic push;
	logic pop;

	assign in_ready = level != FULL;
	assign out_valid = level != '0;
	assign out_data = mem[rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				level <= level + 1'b1;
			end else if (pop && !push) begin
				level <= level - 1'b1;
			end
		end
	end
endmodule : rx_word_fifo

////////////////////////////////////////////////////////////////////////////////

module spi_data_dma_clock_rate_pattern #(
	parameter int DIV_W = 16,
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// AXI4-Lite write address and data.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read.
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Serial pins.
	output logic sclk,
	output logic mosi,
	input wire logic miso,
	output logic ss_n,
	// Controller status.
	output logic busy,
	// Transmit DMA words.
	input wire logic tx_dma_valid,
	input wire logic [31:0] tx_dma_data,
	output logic tx_dma_ready,
	// Receive DMA words.
	output logic rx_dma_valid,
	output logic [31:0] rx_dma_data,
	input wire logic rx_dma_ready
);
	localparam int LW = $clog2(FIFO_DEPTH+1);
	localparam logic [LW-1:0] ROOM_MAX = LW'(FIFO_DEPTH - 2);

	generate
		if (DIV_W < 1 || DIV_W > 16) begin : g_bad_div
			$error("divisor width must lie between 1 and 16");
		end
	endgenerate

	// Registers.
	logic [spi_dv_pkg::LEN_W-1:0] bit_length_field;
	logic transfer_count;
	logic clock_idle_level;
	logic [DIV_W-1:0] divisor_a;
	logic [DIV_W-1:0] divisor_b;
	logic [31:0] transmit_word_first;
	logic [31:0] transmit_word_second;
	logic [31:0] receive_word_first;
	logic [31:0] receive_word_second;
	logic [31:0] clock_rate_pattern;
	logic transmit_dma_go;
	logic receive_dma_go;

	// Bus state.
	logic aw_held;
	logic w_held;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_do;

	// Shifter state.
	spi_dv_pkg::shift_state_t state;
	logic [DIV_W-1:0] cnt;
	logic [5:0] bit_pos;
	logic [4:0] half_idx;
	logic word_idx;
	logic [31:0] tx_cur;
	logic [31:0] rx_shift;
	logic miso_meta;
	logic miso_s;
	logic tx_fill;
	logic tx_take;
	logic last_exchange;

	// Derived configuration.
	logic [5:0] len;
	logic var_mode;
	logic [DIV_W-1:0] half_next;
	logic [4:0] pat_idx;
	logic room;
	logic start;

	// Receive buffer.
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [31:0] fifo_out_data;
	logic fifo_pop_ready;
	logic [LW-1:0] fifo_level;
	logic fifo_push;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction : merge

	////////////////////////////////////////////////////////////////////////////////

	// A length field of zero stands for a full word.
	assign len = (bit_length_field == '0) ? spi_dv_pkg::FULL_LEN : {1'b0, bit_length_field}; // R3
	assign var_mode = !clock_idle_level && (len == spi_dv_pkg::VAR_LEN); // R5
	// The pattern is read per half period, so 16 bits use all 32 pattern bits.
	// The divisor is loaded for the half that starts next, so the index looks one ahead.
	assign pat_idx = (state == spi_dv_pkg::ST_LEAD || state == spi_dv_pkg::ST_TRAIL) ?
		half_idx + 5'h01 : 5'h00;
	assign half_next = (var_mode && clock_rate_pattern[pat_idx]) ? divisor_b : divisor_a; // R4
	assign room = fifo_level <= ROOM_MAX;
	// Receive DMA stalls the shifter until both receive words fit in the buffer.
	assign start = busy && (state == spi_dv_pkg::ST_IDLE) && (!receive_dma_go || room); // R6
	assign last_exchange = (word_idx == transfer_count);
	assign tx_take = tx_dma_valid && tx_dma_ready;
	assign fifo_push = receive_dma_go && (state == spi_dv_pkg::ST_NEXT) && fifo_in_ready; // R6
	assign fifo_pop_ready = !rx_dma_valid || rx_dma_ready;
	assign wr_do = aw_held && w_held && !s_axi_bvalid;

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= spi_dv_pkg::ZERO_WORD;
			wr_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= spi_dv_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				wr_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_do) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				unique case (wr_addr)
					spi_dv_pkg::OFF_CTRL, spi_dv_pkg::OFF_DIV, spi_dv_pkg::OFF_TX0,
					spi_dv_pkg::OFF_TX1, spi_dv_pkg::OFF_PAT, spi_dv_pkg::OFF_DMA,
					spi_dv_pkg::OFF_RX0, spi_dv_pkg::OFF_RX1: begin
						s_axi_bresp <= spi_dv_pkg::RESP_OKAY;
					end
					default: begin
						s_axi_bresp <= spi_dv_pkg::RESP_SLVERR;
					end
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= spi_dv_pkg::ZERO_WORD;
			s_axi_rresp <= spi_dv_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= spi_dv_pkg::RESP_OKAY;
			s_axi_rdata <= spi_dv_pkg::ZERO_WORD;
			unique case (s_axi_araddr)
				spi_dv_pkg::OFF_CTRL: begin
					s_axi_rdata[spi_dv_pkg::CTRL_BUSY] <= busy;
					s_axi_rdata[spi_dv_pkg::LEN_LO +: spi_dv_pkg::LEN_W] <= bit_length_field;
					s_axi_rdata[spi_dv_pkg::CNT_BIT] <= transfer_count;
					s_axi_rdata[spi_dv_pkg::POL_BIT] <= clock_idle_level;
				end
				spi_dv_pkg::OFF_DIV: begin
					s_axi_rdata[DIV_W-1:0] <= divisor_a;
					s_axi_rdata[spi_dv_pkg::DIV_B_LO +: DIV_W] <= divisor_b;
				end
				spi_dv_pkg::OFF_RX0: begin
					s_axi_rdata <= receive_word_first;
				end
				spi_dv_pkg::OFF_RX1: begin
					s_axi_rdata <= receive_word_second;
				end
				spi_dv_pkg::OFF_TX0, spi_dv_pkg::OFF_TX1: begin
					s_axi_rdata <= spi_dv_pkg::ZERO_WORD;
				end
				spi_dv_pkg::OFF_PAT: begin
					s_axi_rdata <= clock_rate_pattern;
				end
				spi_dv_pkg::OFF_DMA: begin
					s_axi_rdata[spi_dv_pkg::DMA_TX_BIT] <= transmit_dma_go;
					s_axi_rdata[spi_dv_pkg::DMA_RX_BIT] <= receive_dma_go;
				end
				default: begin
					s_axi_rresp <= spi_dv_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// Configuration written by software.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bit_length_field <= '0;
			transfer_count <= 1'b0;
			clock_idle_level <= 1'b0;
			divisor_a <= '0;
			divisor_b <= '0;
			clock_rate_pattern <= spi_dv_pkg::PAT_RESET;
			transmit_dma_go <= 1'b0;
			receive_dma_go <= 1'b0;
		end else if (wr_do) begin
			if (wr_addr == spi_dv_pkg::OFF_CTRL && wr_strb[1]) begin
				bit_length_field <= wr_data[spi_dv_pkg::LEN_LO +: spi_dv_pkg::LEN_W];
			end
			if (wr_addr == spi_dv_pkg::OFF_CTRL && wr_strb[2]) begin
				transfer_count <= wr_data[spi_dv_pkg::CNT_BIT];
				clock_idle_level <= wr_data[spi_dv_pkg::POL_BIT];
			end
			if (wr_addr == spi_dv_pkg::OFF_DIV) begin
				divisor_a <= DIV_W'(merge(32'(divisor_a), wr_data, wr_strb));
				divisor_b <= DIV_W'(merge(32'(divisor_b) << spi_dv_pkg::DIV_B_LO, wr_data,
					wr_strb) >> spi_dv_pkg::DIV_B_LO);
			end
			if (wr_addr == spi_dv_pkg::OFF_PAT) begin
				clock_rate_pattern <= merge(clock_rate_pattern, wr_data, wr_strb); // R4
			end
			if (wr_addr == spi_dv_pkg::OFF_DMA && wr_strb[0]) begin
				transmit_dma_go <= wr_data[spi_dv_pkg::DMA_TX_BIT]; // R7
				receive_dma_go <= wr_data[spi_dv_pkg::DMA_RX_BIT]; // R6
			end
		end
	end

	// Transmit words come from software or from the transmit DMA port.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			transmit_word_first <= spi_dv_pkg::ZERO_WORD;
			transmit_word_second <= spi_dv_pkg::ZERO_WORD;
		end else if (tx_take) begin
			if (tx_fill) begin
				transmit_word_second <= tx_dma_data; // R7
			end else begin
				transmit_word_first <= tx_dma_data; // R7
			end
		end else if (wr_do && wr_addr == spi_dv_pkg::OFF_TX0) begin
			transmit_word_first <= merge(transmit_word_first, wr_data, wr_strb); // R1
		end else if (wr_do && wr_addr == spi_dv_pkg::OFF_TX1) begin
			transmit_word_second <= merge(transmit_word_second, wr_data, wr_strb); // R1
		end
	end

	// Transmit DMA requests one word per exchange while the controller is idle.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_fill <= 1'b0;
			tx_dma_ready <= 1'b0;
		end else if (tx_take) begin
			tx_fill <= !(tx_fill == transfer_count) && !tx_fill;
			tx_dma_ready <= !(tx_fill == transfer_count); // R7
		end else begin
			tx_dma_ready <= transmit_dma_go && !busy && (state == spi_dv_pkg::ST_IDLE); // R7
		end
	end

	// Hardware sets busy for DMA and clears it after the last exchange; a set wins.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
		end else if (wr_do && wr_addr == spi_dv_pkg::OFF_CTRL && wr_strb[0] &&
			wr_data[spi_dv_pkg::CTRL_BUSY]) begin
			busy <= 1'b1;
		end else if (tx_take && tx_fill == transfer_count) begin
			busy <= 1'b1; // R8
		end else if (receive_dma_go && !transmit_dma_go && !busy && room &&
			state == spi_dv_pkg::ST_IDLE) begin
			busy <= 1'b1; // R8
		end else if (state == spi_dv_pkg::ST_NEXT && last_exchange) begin
			busy <= 1'b0; // R10
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			miso_meta <= 1'b0;
			miso_s <= 1'b0;
		end else begin
			miso_meta <= miso;
			miso_s <= miso_meta;
		end
	end

	// Data go out and are sampled on the trailing edge; the first bit goes out at start.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= spi_dv_pkg::ST_IDLE;
			cnt <= '0;
			bit_pos <= 6'h00;
			half_idx <= 5'h00;
			word_idx <= 1'b0;
			tx_cur <= spi_dv_pkg::ZERO_WORD;
			rx_shift <= spi_dv_pkg::ZERO_WORD;
			sclk <= 1'b0;
			mosi <= 1'b0;
			ss_n <= 1'b1;
		end else begin
			unique case (state)
				spi_dv_pkg::ST_IDLE: begin
					sclk <= clock_idle_level;
					if (start) begin
						tx_cur <= transmit_word_first; // R1
						bit_pos <= len - 6'h01;
						mosi <= transmit_word_first[5'(len - 6'h01)]; // R2
						rx_shift <= spi_dv_pkg::ZERO_WORD;
						word_idx <= 1'b0;
						half_idx <= 5'h00;
						cnt <= half_next;
						ss_n <= 1'b0;
						state <= spi_dv_pkg::ST_LEAD;
					end else begin
						ss_n <= 1'b1;
					end
				end
				spi_dv_pkg::ST_LEAD: begin
					if (cnt == '0) begin
						sclk <= !sclk;
						half_idx <= half_idx + 5'h01;
						cnt <= half_next;
						state <= spi_dv_pkg::ST_TRAIL;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				spi_dv_pkg::ST_TRAIL: begin
					if (cnt == '0) begin
						sclk <= !sclk;
						half_idx <= half_idx + 5'h01;
						rx_shift <= {rx_shift[30:0], miso_s}; // R9
						if (bit_pos == 6'h00) begin
							state <= spi_dv_pkg::ST_NEXT;
						end else begin
							bit_pos <= bit_pos - 6'h01;
							mosi <= tx_cur[5'(bit_pos - 6'h01)]; // R2
							cnt <= half_next;
							state <= spi_dv_pkg::ST_LEAD;
						end
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				spi_dv_pkg::ST_NEXT: begin
					if (last_exchange) begin
						ss_n <= 1'b1;
						state <= spi_dv_pkg::ST_IDLE; // R10
					end else begin
						tx_cur <= transmit_word_second; // R3
						bit_pos <= len - 6'h01;
						mosi <= transmit_word_second[5'(len - 6'h01)]; // R3
						rx_shift <= spi_dv_pkg::ZERO_WORD;
						word_idx <= 1'b1;
						half_idx <= 5'h00;
						cnt <= half_next;
						state <= spi_dv_pkg::ST_LEAD;
					end
				end
			endcase
		end
	end

	// Receive words keep the last transfer; upper bits stay zero below 32 bits.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			receive_word_first <= spi_dv_pkg::ZERO_WORD;
			receive_word_second <= spi_dv_pkg::ZERO_WORD;
		end else if (state == spi_dv_pkg::ST_NEXT) begin
			if (word_idx) begin
				receive_word_second <= rx_shift; // R9
			end else begin
				receive_word_first <= rx_shift; // R9
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	rx_word_fifo #(
		.WIDTH(32),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk(ref_clk),
		.rst(rst),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.in_data(rx_shift),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop_ready),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);

	// Output stage keeps the DMA port registered.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rx_dma_valid <= 1'b0;
			rx_dma_data <= spi_dv_pkg::ZERO_WORD;
		end else if (fifo_pop_ready) begin
			rx_dma_valid <= fifo_out_valid; // R6
			rx_dma_data <= fifo_out_data;
		end
	end

endmodule : spi_data_dma_clock_rate_pattern

//--- verif/spi_dv_checker.sv
// Checker for the serial data path, bound to the top module's ports.
// Assumes one clock domain, ref_clk, with rst as its asynchronous reset.
`timescale 1ns/1ps
module spi_dv_checker (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Register bus handshakes.
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Link and status.
	input wire logic ss_n,
	input wire logic busy,
	// DMA words.
	input wire logic tx_dma_valid,
	input wire logic tx_dma_ready,
	input wire logic rx_dma_valid,
	input wire logic [31:0] rx_dma_data,
	input wire logic rx_dma_ready
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_tx_take;
		tx_dma_valid && tx_dma_ready;
	endsequence
	a_write_answer: assert property (s_wr_taken |=> !s_axi_awready ##1 s_axi_bvalid)
		else $error("write response not two cycles after take");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not one cycle after take");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	a_frame_start: assert property ($rose(busy) |-> ##[1:2] !ss_n)
		else $error("select not driven after start");
	a_select_busy: assert property ($fell(ss_n) |-> busy)
		else $error("select driven while not busy");
	a_frame_end: assert property ($fell(busy) |=> ss_n)
		else $error("select not released after last exchange");
	a_txdma_idle: assert property (tx_dma_ready |-> !busy)
		else $error("transmit request while busy");
	a_txdma_take: assert property (s_tx_take |=> ##[0:1] (busy || tx_dma_ready))
		else $error("transmit word taken without transfer");
	a_rxdma_held: assert property (rx_dma_valid && !rx_dma_ready |=>
		rx_dma_valid && $stable(rx_dma_data))
		else $error("receive word dropped before taken");
endmodule : spi_dv_checker

bind spi_data_dma_clock_rate_pattern spi_dv_checker u_spi_dv_checker (.ref_clk, .rst, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .ss_n, .busy,
	.tx_dma_valid, .tx_dma_ready, .rx_dma_valid, .rx_dma_data, .rx_dma_ready);

//--- verif/spi_peer_model.sv
// Behavioural serial peripheral standing on the far side of the link.
// Assumes the master samples on trailing edges and launches after them.
`timescale 1ns/1ps
module spi_peer_model (
	// Serial pins.
	input wire logic sclk,
	input wire logic mosi,
	input wire logic ss_n,
	output logic miso,
	// Settings and capture.
	input wire logic pol,
	input wire logic [63:0] reply,
	output logic [63:0] got,
	output int nbits
);
	logic [63:0] shift;
	initial begin
		miso = 1'b0;
		got = '0;
		nbits = 0;
	end
	// Select opens a frame: the reply is loaded and its top bit shown at once.
	always @(negedge ss_n) begin
		shift = reply;
		nbits = 0;
		miso = reply[63];
	end
	// A released line shows the inverse of its last value, so a stale bit cannot pass.
	always @(posedge ss_n) miso = ~miso;
	always @(sclk) begin
		if (ss_n === 1'b0 && sclk !== pol) begin
			got = {got[62:0], mosi};
			nbits = nbits + 1;
		end else if (ss_n === 1'b0) begin
			shift = {shift[62:0], 1'b0};
			miso = shift[63];
		end
	end
endmodule : spi_peer_model

//--- verif/spi_data_dma_clock_rate_pattern_tb.sv
// Self-checking bench: register tasks over AXI4-Lite, a serial peer and DMA drivers.
// Assumes the design package is compiled first and the checker is bound.
`timescale 1ns/1ps
module spi_data_dma_clock_rate_pattern_tb;
	logic ref_clk, rst, miso, sclk, mosi, ss_n, busy, pol;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, tx_dma_data, rx_dma_data, rdat;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic tx_dma_valid, tx_dma_ready, rx_dma_valid, rx_dma_ready;
	logic [63:0] reply, got;
	int nbits, hi_cnt, n_mismatch, num_checks;
	int lens[3] = '{16, 8, 16};
	int hi_exp[3] = '{96, 16, 32};
	spi_data_dma_clock_rate_pattern #(.DIV_W(16), .FIFO_DEPTH(8)) u_spi_data_dma_clock_rate_pattern (.ref_clk, .rst,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sclk, .mosi,
		.miso, .ss_n, .busy, .tx_dma_valid, .tx_dma_data, .tx_dma_ready, .rx_dma_valid,
		.rx_dma_data, .rx_dma_ready);
	spi_peer_model u_spi_peer_model (.sclk, .mosi, .ss_n, .miso, .pol, .reply, .got, .nbits);
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// Counts cycles spent in the active half of each serial clock period.
	always @(posedge ref_clk) if (ss_n === 1'b0 && sclk !== pol) hi_cnt <= hi_cnt + 1;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge ref_clk);
			if (!aw_done && s_axi_awready === 1'b1) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready === 1'b1) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
	endtask : axi_rd
	// Waits for a transfer to begin and end; a hang is cut by the watchdog.
	task automatic wait_idle();
		int k;
		k = 0;
		while (busy !== 1'b1 && k < 100) begin
			@(posedge ref_clk);
			k++;
		end
		while (busy !== 1'b0) @(posedge ref_clk);
		repeat (3) @(posedge ref_clk);
	endtask : wait_idle
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge ref_clk);
		n_mismatch++;
		summarize();
	end
	initial begin
		int k, n;
		logic [31:0] c;
		{rst, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7f;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, tx_dma_valid, rx_dma_ready, pol} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, tx_dma_data, hi_cnt} = '0;
		reply = 64'hc35a_0f96_e187_2b4d;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		axi_rd(spi_dv_pkg::OFF_PAT);
		chk(rdat, spi_dv_pkg::PAT_RESET);
		axi_rd(spi_dv_pkg::OFF_DMA);
		chk(rdat, spi_dv_pkg::ZERO_WORD);
		axi_rd(8'h3c);
		chk(resp, spi_dv_pkg::RESP_SLVERR);
		axi_wr(8'h3c, 32'h00000001);
		chk(resp, spi_dv_pkg::RESP_SLVERR);
		axi_wr(spi_dv_pkg::OFF_DIV, 32'h00050003);
		axi_rd(spi_dv_pkg::OFF_DIV);
		chk(rdat, 32'h00050003);
		axi_wr(spi_dv_pkg::OFF_TX0, 32'h123456a5);
		axi_wr(spi_dv_pkg::OFF_CTRL, 32'h00000801);
		wait_idle();
		chk(nbits, 8);
		chk(got[7:0], 8'ha5);
		axi_rd(spi_dv_pkg::OFF_RX0);
		chk(rdat, 32'h000000c3);
		axi_wr(spi_dv_pkg::OFF_TX0, 32'h12345678);
		axi_wr(spi_dv_pkg::OFF_TX1, 32'h9abcdef0);
		axi_wr(spi_dv_pkg::OFF_CTRL, 32'h00010001);
		wait_idle();
		chk(nbits, 64);
		chk(got, 64'h12345678_9abcdef0);
		axi_rd(spi_dv_pkg::OFF_RX0);
		chk(rdat, reply[63:32]);
		axi_rd(spi_dv_pkg::OFF_RX1);
		chk(rdat, reply[31:0]);
		chk(busy, 1'b0);
		axi_wr(spi_dv_pkg::OFF_DIV, 32'h00050001);
		axi_wr(spi_dv_pkg::OFF_PAT, 32'haaaaaaaa);
		axi_rd(spi_dv_pkg::OFF_PAT);
		chk(rdat, 32'haaaaaaaa);
		for (int i = 0; i < 3; i++) begin
			c = (32'(i == 2) << 17) | (32'(lens[i]) << 8);
			pol = (i == 2);
			axi_wr(spi_dv_pkg::OFF_CTRL, c);
			hi_cnt = 0;
			axi_wr(spi_dv_pkg::OFF_CTRL, c | 32'h1);
			wait_idle();
			chk(hi_cnt, hi_exp[i]);
		end
		pol = 1'b0;
		axi_wr(spi_dv_pkg::OFF_CTRL, 32'h00000800);
		axi_wr(spi_dv_pkg::OFF_DIV, 32'h00000003);
		axi_wr(spi_dv_pkg::OFF_DMA, 32'h00000001);
		tx_dma_data <= 32'h0000003c;
		tx_dma_valid <= 1'b1;
		do @(posedge ref_clk); while (tx_dma_ready !== 1'b1);
		tx_dma_valid <= 1'b0;
		wait_idle();
		chk(nbits, 8);
		chk(got[7:0], 8'h3c);
		axi_wr(spi_dv_pkg::OFF_DMA, 32'h00000002);
		k = 0;
		while (k < 200) begin
			@(posedge ref_clk);
			k = (busy === 1'b1) ? 0 : k + 1;
		end
		axi_wr(spi_dv_pkg::OFF_DMA, 32'h00000000);
		rx_dma_ready <= 1'b1;
		n = 0;
		k = 0;
		while (k < 20) begin
			@(posedge ref_clk);
			if (rx_dma_valid === 1'b1) begin
				chk(rx_dma_data, 32'h000000c3);
				n++;
				k = 0;
			end else begin
				k++;
			end
		end
		chk(n, 8);
		summarize();
	end
endmodule : spi_data_dma_clock_rate_pattern_tb
